// ==== pkg/jtag_scan_pkg.sv ====
// Constants and types for the boundary-scan test port block
package jtag_scan_pkg;
	localparam int PINS = 8;
	localparam int BSC_LEN = 2 * PINS;
	localparam int DBG_LEN = 9;

	localparam logic [3:0] OP_EXTEST = 4'h0;
	localparam logic [3:0] OP_IDCODE = 4'h1;
	localparam logic [3:0] OP_SAMPLE = 4'h2;
	localparam logic [3:0] OP_DEBUG_ZERO = 4'h8;
	localparam logic [3:0] OP_DEBUG_THREE = 4'hB;
	localparam logic [3:0] OP_PART_RESET = 4'hC;
	localparam logic [3:0] OP_BYPASS = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// Part number and maker values are arbitrary
	localparam logic [3:0] ID_VERSION = 4'h0;
	localparam logic [15:0] ID_PART = 16'hA5C3;
	localparam logic [10:0] ID_MAKER = 11'h155;
	localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

	localparam logic [7:0] ADDR_CHANNEL = 8'h00;
	localparam logic [7:0] ADDR_CPU_CTRL = 8'h04;
	localparam logic [7:0] ADDR_FUSES = 8'h08;
	localparam logic [7:0] ADDR_ERASE = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	localparam int CTRL_SOFT_DISABLE = 0;
	localparam int FUSE_PORT_EN = 0;
	localparam int FUSE_DEBUG_EN = 1;
	localparam int FUSE_LOCK1 = 2;
	localparam int FUSE_LOCK2 = 3;
	localparam int FUSE_CKSEL = 4;
	localparam int ERASE_GO = 0;
	localparam int DBG_ACCESS = 0;
	localparam int DBG_ACK = 8;
	localparam logic [7:0] FUSES_RESET = 8'h01;

	localparam int CLK_NS = 4;
	localparam int TO_NS0 = 16;
	localparam int TO_NS1 = 256;
	localparam int TO_NS2 = 4096;
	localparam int TO_NS3 = 16384;
	localparam logic [12:0] TO_CYC0 = 13'((TO_NS0 + CLK_NS - 1) / CLK_NS);
	localparam logic [12:0] TO_CYC1 = 13'((TO_NS1 + CLK_NS - 1) / CLK_NS);
	localparam logic [12:0] TO_CYC2 = 13'((TO_NS2 + CLK_NS - 1) / CLK_NS);
	localparam logic [12:0] TO_CYC3 = 13'((TO_NS3 + CLK_NS - 1) / CLK_NS);

	typedef enum logic [3:0] {
		TLR, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} tap_state_t;

	typedef struct packed {
		logic [PINS-1:0] out;
		logic [PINS-1:0] oe;
	} pin_drive_t;

	typedef struct packed {
		logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2, rst_s1, rst_s2;
		logic [PINS-1:0] pin_s1;
		logic [PINS-1:0] pin_s2;
		tap_state_t tap;
		logic [3:0] ir;
		logic [3:0] ir_sh;
		logic [31:0] dr_sh;
		logic rst_bit;
		logic [BSC_LEN-1:0] bs_latch;
		logic [7:0] chan_byte;
		logic dirty;
		logic chan_access;
		logic [7:0] gp_byte;
		logic soft_disable;
		logic [7:0] fuses;
		logic [12:0] to_cnt;
		logic part_reset;
		logic tdo;
		logic tdo_oe;
		pin_drive_t pin_drive;
		logic ready;
		logic resp;
		logic [31:0] rdata;
		logic wr_pend;
		logic [7:0] wr_addr;
	} scan_state_t;

	localparam scan_state_t STATE_RESET = '{tap: TLR, ir: OP_IDCODE, fuses: FUSES_RESET, ready: 1'b1,
		rst_s1: 1'b1, rst_s2: 1'b1, default: '0};
endpackage

// ==== design/jtag_scan_port.sv ====
// Boundary-scan test port with debug byte channel and AHB-Lite register slave
//
// Notes on behaviour
// - Opcodes 0x8 to 0xB select the debug channel scan register.
// - Port works only with enable fuse programmed and soft disable clear.
// - Debug fuse cannot be programmed while a lock bit is set, until erase.
// - CPU write to the channel stores the byte and sets the dirty flag.
// - CPU read of the channel gives seven low bits, dirty flag on top.
// - Channel is visible only with debug fuse and debugger access, else plain byte.
// - Identification is the default instruction after start-up and reset state.
// - External test drives the output latches on pins as soon as loaded.
// - Sample captures the pin states while the part runs normally.
// - Scan logic runs on the core clock and acts on sampled test clock edges, so the core clock is needed.
// - Bypass is one stage, loaded with zero on capture.
// - Identification word: version, part number, maker, constant one.
// - Version field counts silicon revisions from zero.
// - A one in the reset bit holds the part in reset at once.
// - After release the part stays reset for the fused time-out.
// - In reset every port pin goes to high impedance, except under external test, which keeps driving the latches.
// - Reset comes from the reset pin low or the reset bit.
// - Instruction register is four bits wide.
// - All shift registers move least significant bit first.
// - External test captures pins and applies the chain on update.
// - Identification instruction selects the 32-bit identification register.
// - Sample updates the output latches without connecting them to pins.
// - Reset instruction selects the one-bit reset register, opcode 0xF bypass.
`timescale 1ns/10ps
`default_nettype none

module jtag_scan_port
	import jtag_scan_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic reset_pin_n,
	output logic part_reset,
	input wire logic [PINS-1:0] pin_in,
	input wire pin_drive_t core_drive,
	output pin_drive_t pin_drive
);

	////////////////////////////////////////////////////////////////////////////
	function automatic tap_state_t tap_next(tap_state_t st, logic t);
		unique case (st)
			TLR: tap_next = t ? TLR : IDLE;
			IDLE: tap_next = t ? SEL_DR : IDLE;
			SEL_DR: tap_next = t ? SEL_IR : CAP_DR;
			CAP_DR: tap_next = t ? EX1_DR : SH_DR;
			SH_DR: tap_next = t ? EX1_DR : SH_DR;
			EX1_DR: tap_next = t ? UPD_DR : PAU_DR;
			PAU_DR: tap_next = t ? EX2_DR : PAU_DR;
			EX2_DR: tap_next = t ? UPD_DR : SH_DR;
			UPD_DR: tap_next = t ? SEL_DR : IDLE;
			SEL_IR: tap_next = t ? TLR : CAP_IR;
			CAP_IR: tap_next = t ? EX1_IR : SH_IR;
			SH_IR: tap_next = t ? EX1_IR : SH_IR;
			EX1_IR: tap_next = t ? UPD_IR : PAU_IR;
			PAU_IR: tap_next = t ? EX2_IR : PAU_IR;
			EX2_IR: tap_next = t ? UPD_IR : SH_IR;
			UPD_IR: tap_next = t ? SEL_DR : IDLE;
		endcase
	endfunction

	function automatic logic is_debug(logic [3:0] op);
		is_debug = (op >= OP_DEBUG_ZERO) && (op <= OP_DEBUG_THREE);
	endfunction

	function automatic logic is_boundary(logic [3:0] op);
		is_boundary = (op == OP_EXTEST) || (op == OP_SAMPLE);
	endfunction

	// Index where TDI enters the selected register; unknown opcodes act as bypass
	function automatic logic [4:0] dr_msb(logic [3:0] op);
		if (op == OP_IDCODE) begin
			dr_msb = 5'h1F;
		end else if (is_boundary(op)) begin
			dr_msb = 5'(BSC_LEN - 1);
		end else if (is_debug(op)) begin
			dr_msb = 5'(DBG_LEN - 1);
		end else begin
			dr_msb = 5'h00;
		end
	endfunction

	function automatic logic [12:0] timeout_cycles(logic [1:0] sel);
		unique case (sel)
			2'h0: timeout_cycles = TO_CYC0;
			2'h1: timeout_cycles = TO_CYC1;
			2'h2: timeout_cycles = TO_CYC2;
			2'h3: timeout_cycles = TO_CYC3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	scan_state_t s;
	scan_state_t n;
	logic tap_on;
	logic rise;
	logic fall;
	logic extest_on;
	logic reset_src;
	logic chan_visible;
	logic acc;

	assign tap_on = s.fuses[FUSE_PORT_EN] & ~s.soft_disable;
	// Edges seen on the core clock; TCK must stay under a quarter of hclk
	assign rise = s.tck_s2 & ~s.tck_s3;
	assign fall = ~s.tck_s2 & s.tck_s3;
	assign extest_on = tap_on & (s.ir == OP_EXTEST);
	assign reset_src = ~s.rst_s2 | s.rst_bit;
	assign chan_visible = s.fuses[FUSE_DEBUG_EN] & s.chan_access;
	assign acc = hsel & htrans[1] & hready;

	assign hrdata = s.rdata;
	assign hreadyout = s.ready;
	assign hresp = s.resp;
	assign tdo = s.tdo;
	assign tdo_oe = s.tdo_oe;
	assign part_reset = s.part_reset;
	assign pin_drive = s.pin_drive;

	always_comb begin
		n = s;
		n.tck_s1 = tck;
		n.tck_s2 = s.tck_s1;
		n.tck_s3 = s.tck_s2;
		n.tms_s1 = tms;
		n.tms_s2 = s.tms_s1;
		n.tdi_s1 = tdi;
		n.tdi_s2 = s.tdi_s1;
		n.rst_s1 = reset_pin_n;
		n.rst_s2 = s.rst_s1;
		n.pin_s1 = pin_in;
		n.pin_s2 = s.pin_s1;

		// Test port: rising edge captures and shifts, falling edge updates and drives TDO
		if (!tap_on) begin
			n.tap = TLR;
			n.ir = OP_IDCODE;
			n.tdo_oe = 1'b0;
		end else if (rise) begin
			if (s.tap == CAP_IR) begin
				n.ir_sh = IR_CAPTURE;
			end
			if (s.tap == SH_IR) begin
				n.ir_sh = {s.tdi_s2, s.ir_sh[3:1]};
			end
			if (s.tap == CAP_DR) begin
				if (s.ir == OP_IDCODE) begin
					n.dr_sh = ID_WORD;
				end else if (is_boundary(s.ir)) begin
					// Pins are read without changing their drive: the core under sample, the latches under external test
					for (int i = 0; i < PINS; i++) begin
						n.dr_sh[2*i] = s.pin_s2[i];
						n.dr_sh[2*i+1] = s.pin_drive.oe[i];
					end
				end else if (is_debug(s.ir)) begin
					n.dr_sh[DBG_LEN-1:0] = {s.dirty, s.chan_byte};
				end else if (s.ir != OP_PART_RESET) begin
					n.dr_sh[0] = 1'b0;
				end
			end
			if (s.tap == SH_DR) begin
				if (s.ir == OP_PART_RESET) begin
					n.rst_bit = s.tdi_s2;
				end else begin
					n.dr_sh = s.dr_sh >> 1;
					n.dr_sh[dr_msb(s.ir)] = s.tdi_s2;
				end
			end
			n.tap = tap_next(s.tap, s.tms_s2);
		end else if (fall) begin
			n.tdo_oe = (s.tap == SH_IR) || (s.tap == SH_DR);
			if (s.tap == SH_IR) begin
				n.tdo = s.ir_sh[0];
			end else if (s.tap == SH_DR) begin
				n.tdo = (s.ir == OP_PART_RESET) ? s.rst_bit : s.dr_sh[0];
			end
			if (s.tap == UPD_IR) begin
				n.ir = s.ir_sh;
			end else if (s.tap == TLR) begin
				n.ir = OP_IDCODE;
			end
			if (s.tap == UPD_DR && is_boundary(s.ir)) begin
				n.bs_latch = s.dr_sh[BSC_LEN-1:0];
			end
			if (s.tap == UPD_DR && is_debug(s.ir)) begin
				n.chan_access = s.dr_sh[DBG_ACCESS];
				if (s.dr_sh[DBG_ACK]) begin
					n.dirty = 1'b0;
				end
			end
		end

		// Reset hold and time-out; the reset bit acts without any update latch
		if (reset_src) begin
			n.to_cnt = timeout_cycles(s.fuses[FUSE_CKSEL +: 2]);
			n.part_reset = 1'b1;
		end else if (s.to_cnt != 13'h0000) begin
			n.to_cnt = s.to_cnt - 13'h0001;
			n.part_reset = 1'b1;
		end else begin
			n.part_reset = 1'b0;
		end

		// Pin drivers; external test wins over reset so a board test can hold the core
		if (extest_on) begin
			for (int i = 0; i < PINS; i++) begin
				n.pin_drive.out[i] = s.bs_latch[2*i];
				n.pin_drive.oe[i] = s.bs_latch[2*i+1];
			end
		end else if (reset_src || s.part_reset) begin
			n.pin_drive.out = core_drive.out;
			n.pin_drive.oe = '0;
		end else begin
			n.pin_drive = core_drive;
		end

		// Bus slave: zero wait states, reads answered from the address phase
		n.ready = 1'b1;
		n.resp = 1'b0;
		n.wr_pend = acc & hwrite;
		if (acc) begin
			n.wr_addr = haddr[7:0];
		end
		if (acc && !hwrite) begin
			n.rdata = '0;
			case (haddr[7:0])
				ADDR_CHANNEL: begin
					if (chan_visible) begin
						n.rdata[7:0] = {s.dirty, s.chan_byte[6:0]};
					end else begin
						n.rdata[7:0] = s.gp_byte;
					end
				end
				ADDR_CPU_CTRL: n.rdata[CTRL_SOFT_DISABLE] = s.soft_disable;
				ADDR_FUSES: n.rdata[7:0] = s.fuses;
				ADDR_STATUS: n.rdata[11:0] = {s.ir, 4'h0, s.chan_access, s.dirty, tap_on, s.part_reset};
				default: n.rdata = '0;
			endcase
		end
		if (s.wr_pend) begin
			case (s.wr_addr)
				ADDR_CHANNEL: begin
					if (chan_visible) begin
						n.chan_byte = hwdata[7:0];
						n.dirty = 1'b1;
					end else begin
						n.gp_byte = hwdata[7:0];
					end
				end
				ADDR_CPU_CTRL: n.soft_disable = hwdata[CTRL_SOFT_DISABLE];
				ADDR_FUSES: begin
					n.fuses = hwdata[7:0];
					if (s.fuses[FUSE_LOCK1] | s.fuses[FUSE_LOCK2]) begin
						n.fuses[FUSE_DEBUG_EN] = s.fuses[FUSE_DEBUG_EN] & hwdata[FUSE_DEBUG_EN];
					end
				end
				ADDR_ERASE: begin
					if (hwdata[ERASE_GO]) begin
						n.fuses[FUSE_LOCK1] = 1'b0;
						n.fuses[FUSE_LOCK2] = 1'b0;
					end
				end
				default: n.gp_byte = s.gp_byte;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= STATE_RESET;
		end else if (ce) begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_port_off;
		ce && !tap_on |=> s.tap == TLR && s.ir == OP_IDCODE;
	endproperty
	a_port_off: assert property (p_port_off) else $error("port not held in reset state");

	property p_ir_capture;
		ce && tap_on && rise && s.tap == CAP_IR |=> s.ir_sh == 4'h1;
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("wrong instruction capture");

	property p_bypass_zero;
		ce && tap_on && rise && s.tap == CAP_DR && s.ir == OP_BYPASS |=> !s.dr_sh[0];
	endproperty
	a_bypass_zero: assert property (p_bypass_zero) else $error("bypass not cleared");

	property p_id_capture;
		ce && tap_on && rise && s.tap == CAP_DR && s.ir == OP_IDCODE |=> s.dr_sh == ID_WORD && s.dr_sh[0];
	endproperty
	a_id_capture: assert property (p_id_capture) else $error("identification not captured");

	property p_debug_capture;
		ce && tap_on && rise && s.tap == CAP_DR && s.ir[3:2] == 2'h2
			|=> s.dr_sh[8:0] == {$past(s.dirty), $past(s.chan_byte)};
	endproperty
	a_debug_capture: assert property (p_debug_capture) else $error("debug channel not captured");

	property p_sample_pins;
		ce && tap_on && rise && s.tap == CAP_DR && s.ir == OP_SAMPLE |=> s.dr_sh[0] == $past(s.pin_s2[0]);
	endproperty
	a_sample_pins: assert property (p_sample_pins) else $error("pin snapshot wrong");

	property p_shift_lsb;
		ce && tap_on && rise && s.tap == SH_DR && s.ir == OP_IDCODE
			|=> s.dr_sh[31] == $past(s.tdi_s2) && s.dr_sh[30:0] == $past(s.dr_sh[31:1]);
	endproperty
	a_shift_lsb: assert property (p_shift_lsb) else $error("shift order wrong");

	property p_reset_bit;
		ce && tap_on && rise && s.tap == SH_DR && s.ir == OP_PART_RESET && s.tdi_s2
			|=> s.rst_bit ##1 s.part_reset;
	endproperty
	a_reset_bit: assert property (p_reset_bit) else $error("reset bit did not reset part");

	property p_timeout;
		ce && $fell(reset_src) && s.fuses[5:4] == 2'h0 |-> s.part_reset [*5] ##1 !s.part_reset;
	endproperty
	a_timeout: assert property (p_timeout) else $error("reset time-out length wrong");

	property p_pins_float;
		ce && reset_src && !extest_on |=> s.pin_drive.oe == '0;
	endproperty
	a_pins_float: assert property (p_pins_float) else $error("pins driven in reset");

	property p_extest_drive;
		ce && extest_on |=> s.pin_drive.oe[0] == $past(s.bs_latch[1]) && s.pin_drive.out[0] == $past(s.bs_latch[0]);
	endproperty
	a_extest_drive: assert property (p_extest_drive) else $error("latches not on pins");

	property p_dirty_set;
		ce && s.wr_pend && s.wr_addr == ADDR_CHANNEL && chan_visible
			|=> s.dirty && s.chan_byte == $past(hwdata[7:0]);
	endproperty
	a_dirty_set: assert property (p_dirty_set) else $error("channel write lost");

	property p_lock_fuse;
		ce && s.wr_pend && s.wr_addr == ADDR_FUSES && s.fuses[3:2] != 2'h0 && !s.fuses[1] |=> !s.fuses[1];
	endproperty
	a_lock_fuse: assert property (p_lock_fuse) else $error("debug fuse set while locked");

	property p_tap_exit;
		ce && tap_on && rise && s.tap == SH_DR && s.tms_s2 |=> s.tap == EX1_DR;
	endproperty
	a_tap_exit: assert property (p_tap_exit) else $error("controller sequencing wrong");

	c_id_scan: cover property (ce && rise && s.tap == SH_DR && s.ir == OP_IDCODE);
	c_extest: cover property (extest_on && s.pin_drive.oe != '0);
	c_part_reset: cover property ($fell(s.part_reset));
	c_dirty_clear: cover property ($fell(s.dirty));

endmodule

`default_nettype wire

// ==== tb/jtag_probe.sv ====
// Behavioural test controller that drives the scan port link
`timescale 1ns/10ps
`default_nettype none

module jtag_probe (
	input wire logic hclk,
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input wire logic tdo
);
	// Half of a 48 ns link period in core cycles; the link clock rests low between frames
	localparam int HALF = 6;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tdo is taken just before the rising edge, long after the port moved it
	task automatic tick(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		repeat (HALF) @(posedge hclk);
		q = tdo;
		tck <= 1'b1;
		repeat (HALF) @(posedge hclk);
		tck <= 1'b0;
	endtask

	task automatic reset_tap;
		logic q;
		repeat (5) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask

	// From idle to shift, n bits, then update and back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, 1'b0, q);
		if (ir) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask
endmodule

`default_nettype wire

// ==== tb/jtag_scan_port_tb.sv ====
// Self-checking bench for the scan port block
`timescale 1ns/10ps
`default_nettype none

module jtag_scan_port_tb
	import jtag_scan_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, tck, tms, tdi, tdo, tdo_oe, reset_pin_n, part_reset, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rnd, r, v;
	logic [1:0] htrans;
	logic [7:0] pin_in, b;
	logic [15:0] d;
	logic [3:0] ops [9] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
	pin_drive_t core_drive, pin_drive;
	int n_errors, cmp_count, cyc, n;
	logic oe_seen;

	jtag_scan_port uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.reset_pin_n(reset_pin_n), .part_reset(part_reset), .pin_in(pin_in), .core_drive(core_drive),
		.pin_drive(pin_drive));
	jtag_probe probe (.hclk(hclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic pin_drive_t drv_of(input logic [15:0] c);
		pin_drive_t p;
		for (int i = 0; i < PINS; i++) begin
			p.out[i] = c[2 * i];
			p.oe[i] = c[2 * i + 1];
		end
		return p;
	endfunction

	function automatic logic [15:0] even(input logic [7:0] q);
		logic [15:0] e;
		e = '0;
		for (int i = 0; i < PINS; i++) e[2 * i] = q[i];
		return e;
	endfunction

	// Release time-out in core cycles for clock options 0 to 2
	function automatic int to_of(input int k);
		return (k == 0) ? TO_NS0 / CLK_NS : (k == 1) ? TO_NS1 / CLK_NS : TO_NS2 / CLK_NS;
	endfunction

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// One single word transfer; read data lands in v
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask

	task automatic sc(input logic ir, input int n, input logic [31:0] din);
		probe.scan(ir, n, din, r);
	endtask

	// A hang costs one mismatch and closes the run
	always @(posedge hclk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			end_of_test;
		end
	end

	// Remembers that the data pin was ever driven during a shift
	always @(posedge hclk) begin
		if (tdo_oe === 1'b1) oe_seen <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = '0;
		hwrite = 1'b0;
		hwdata = '0;
		reset_pin_n = 1'b1;
		pin_in = '0;
		core_drive = '0;
		n_errors = 0;
		cmp_count = 0;
		cyc = 0;
		oe_seen = 1'b0;
		rnd = 32'h323D592D;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, ADDR_STATUS, '0);
		check("status", v, 32'h0000_0102);
		ahb(1'b0, ADDR_FUSES, '0);
		check("fuses", v, {24'h0, FUSES_RESET});
		check("hresp", {31'h0, hresp}, 32'h0);
		rnd = lfsr(rnd);
		core_drive <= rnd[15:0];
		repeat (4) @(posedge hclk);
		check("drive", pin_drive, core_drive);
		done("reset");
		probe.reset_tap;
		sc(1'b0, 32, rnd);
		check("idcode", r, ID_WORD);
		check("tdo_oe", {oe_seen, tdo_oe}, 32'h2);
		foreach (ops[k]) begin
			sc(1'b1, 4, {28'h0, ops[k]});
			check("ir capture", r, 32'h1);
			ahb(1'b0, ADDR_STATUS, '0);
			check("ir", v[11:8], ops[k]);
		end
		for (int k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			sc(1'b0, 8, rnd);
			check("bypass", r[7:0], {rnd[6:0], 1'b0});
		end
		done("instructions");
		ahb(1'b1, ADDR_FUSES, 32'h05);
		ahb(1'b1, ADDR_FUSES, 32'h07);
		ahb(1'b0, ADDR_FUSES, '0);
		check("locked fuse", v, 32'h05);
		ahb(1'b1, ADDR_FUSES, 32'h09);
		ahb(1'b1, ADDR_FUSES, 32'h0B);
		ahb(1'b0, ADDR_FUSES, '0);
		check("second lock", v, 32'h09);
		ahb(1'b1, ADDR_ERASE, 32'h1);
		ahb(1'b1, ADDR_FUSES, 32'h03);
		ahb(1'b0, ADDR_FUSES, '0);
		check("erased fuse", v, 32'h03);
		done("lock");
		rnd = lfsr(rnd);
		ahb(1'b1, ADDR_CHANNEL, {24'h0, rnd[7:0]});
		ahb(1'b0, ADDR_CHANNEL, '0);
		check("plain byte", v, {24'h0, rnd[7:0]});
		sc(1'b1, 4, 32'h8);
		sc(1'b0, 9, 32'h001);
		b = rnd[15:8];
		ahb(1'b1, ADDR_CHANNEL, {24'h0, b});
		ahb(1'b0, ADDR_CHANNEL, '0);
		check("channel", v, {24'h0, 1'b1, b[6:0]});
		for (int k = 9; k < 12; k++) begin
			sc(1'b1, 4, k);
			sc(1'b0, 9, 32'h001);
			check("debug chain", r[8:0], {1'b1, b});
		end
		// The controller clears the flag once it has the byte
		sc(1'b0, 9, 32'h101);
		ahb(1'b0, ADDR_CHANNEL, '0);
		check("cleared", v, {24'h0, 1'b0, b[6:0]});
		done("channel");
		ahb(1'b1, ADDR_CPU_CTRL, 32'h1);
		sc(1'b1, 4, 32'hF);
		ahb(1'b0, ADDR_STATUS, '0);
		check("soft off", {v[11:8], v[1]}, 32'h02);
		ahb(1'b1, ADDR_CPU_CTRL, 32'h0);
		ahb(1'b1, ADDR_FUSES, 32'h02);
		ahb(1'b0, ADDR_STATUS, '0);
		check("fuse off", v[1], 32'h0);
		ahb(1'b1, ADDR_FUSES, 32'h31);
		probe.reset_tap;
		done("disable");
		sc(1'b1, 4, 32'hC);
		sc(1'b0, 1, 32'h1);
		check("reset bit", {part_reset, pin_drive.oe}, 32'h100);
		sc(1'b0, 1, 32'h0);
		for (n = 0; n < 5000 && part_reset === 1'b1; n++) @(posedge hclk);
		check("timeout", n > 3900 && n < 4097, 32'h1);
		// Pin reset under each of the shorter clock options
		for (int k = 0; k < 3; k++) begin
			ahb(1'b1, ADDR_FUSES, 32'h01 | (k << FUSE_CKSEL));
			reset_pin_n <= 1'b0;
			repeat (6) @(posedge hclk);
			check("pin reset", part_reset, 32'h1);
			reset_pin_n <= 1'b1;
			for (n = 0; n < 2000 && part_reset === 1'b1; n++) @(posedge hclk);
			check("short timeout", n > to_of(k) && n < to_of(k) + 8, 32'h1);
		end
		done("reset register");
		rnd = lfsr(rnd);
		pin_in <= rnd[7:0];
		d = rnd[31:16];
		// Safe values go into the latches before the drive is switched over
		sc(1'b1, 4, {28'h0, OP_SAMPLE});
		sc(1'b0, 16, d);
		check("sample", r[15:0] & 16'h5555, even(pin_in));
		check("sample drive", pin_drive, core_drive);
		sc(1'b1, 4, {28'h0, OP_EXTEST});
		check("extest drive", pin_drive, drv_of(d));
		rnd = lfsr(rnd);
		pin_in <= rnd[7:0];
		sc(1'b0, 16, rnd[31:16]);
		check("extest capture", r[15:0] & 16'h5555, even(pin_in));
		check("extest update", pin_drive, drv_of(rnd[31:16]));
		done("boundary");
		end_of_test;
	end
endmodule

`default_nettype wire
